// ==== include/flash_read_map.svh ====
// Address map, command codes, buffer selects, reset values and timing counts of the flash read port.
// Assumes a 25 MHz system clock; included by the package users by bare name.
`ifndef FLASH_READ_MAP_SVH
`define FLASH_READ_MAP_SVH
`define RSV_MAIN_LO 16'h0A00
`define RSV_MAIN_HI 16'h7FFF
`define RSV_REG_LO 16'h9000
`define RSV_REG_HI 16'hEFFF
`define LAT_RESET 3'h4
`define LAT_MAX 3'h7
`define LAT_MIN 3'h3
`define CMD_LOAD 16'h0000
`define CMD_CACHE_FIRST 16'h000E
`define CMD_CACHE_NEXT 16'h000F
`define CMD_CACHE_FINISH 16'h000C
`define BSA_RAM0 4'h8
`define BSA_RAM1 4'hC
`define SENSE_CYCLES 8'h20
`define XFER_CYCLES 8'h10
`endif

// ==== include/flash_read_pkg.sv ====
// Types shared by the flash read port and its helpers.
// Assumes the map header supplies all numeric constants.
package flash_read_pkg;
  typedef enum logic [2:0] {BL_CONT, BL_4, BL_8, BL_16, BL_32} burst_len_e;
  typedef enum logic [1:0] {RD_IDLE, RD_LAT, RD_BURST} read_state_e;
  typedef enum logic [2:0] {CR_IDLE, CR_LOAD_SENSE, CR_LOAD_XFER, CR_OVERLAP, CR_WAIT,
    CR_FINISH_XFER} cache_state_e;
endpackage

// ==== design/read_fifo.sv ====
// Small flop FIFO in the read data path toward the pins.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module read_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== design/burst_addr_gen.sv ====
// Next burst address: wraps inside the aligned group for fixed lengths.
// Assumes the caller holds the current address in a register.
`timescale 1ns/1ps
module burst_addr_gen
  import flash_read_pkg::*;
(
  input wire logic [15:0] addr,
  input wire burst_len_e len,
  output logic [15:0] next_addr
);
  logic [15:0] mask;
  always_comb begin
    unique case (len)
      BL_4: mask = 16'h0003;
      BL_8: mask = 16'h0007;
      BL_16: mask = 16'h000F;
      BL_32: mask = 16'h001F;
      default: mask = 16'hFFFF;
    endcase
    next_addr = (addr & ~mask) | ((addr + 16'h0001) & mask);
  end
endmodule

// ==== design/flash_host_read_port.sv ====
// Host read port of the flash: async and burst reads of buffer memory, cache read control.
// Assumes host pins are synchronous to clk; the buffer memory answers reads combinationally.
`timescale 1ns/1ps
`include "flash_read_map.svh"
module flash_host_read_port
  import flash_read_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic address_latch_strobe_n,
  input wire logic hardware_reset_input_n,
  input wire logic soft_reset,
  input wire logic burst_clk_en,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic ready,
  input wire logic read_mode_select,
  input wire logic write_mode_select,
  input wire logic [2:0] burst_read_latency,
  input wire logic latency_write,
  input wire logic high_frequency_flag,
  input wire burst_len_e burst_length,
  output logic [2:0] latency_setting,
  output logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_code,
  input wire logic addr_write,
  input wire logic auto_int_mode,
  input wire logic int_clear,
  input wire logic [3:0] buffer_select_addr,
  input wire logic [1:0] buffer_sector_count,
  input wire logic [15:0] flash_block_addr,
  input wire logic [5:0] flash_page_addr,
  input wire logic [1:0] flash_sector_addr,
  input wire logic [15:0] copy_block_addr,
  input wire logic [5:0] copy_page_addr,
  input wire logic [1:0] copy_sector_addr,
  output logic int_out,
  output logic sense_active,
  output logic xfer_active,
  output logic [3:0] xfer_buffer,
  output logic [15:0] sense_block,
  output logic [5:0] sense_page,
  output logic cache_fail,
  output logic addr_accepted
);
  read_state_e rd_state_r;
  cache_state_e cr_state_r;
  logic [2:0] lat_r;
  logic [2:0] lat_cnt_r;
  logic [15:0] addr_r;
  logic [15:0] next_addr;
  logic async_valid_r;
  logic ready_r;
  logic [15:0] data_r;
  logic burst_live;
  logic stop_burst;
  logic reserved;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic [15:0] f_out_data;
  logic cycle_start;
  logic [7:0] sense_cnt_r;
  logic [7:0] xfer_cnt_r;
  logic sense_busy_r;
  logic xfer_busy_r;
  logic [3:0] bsa_r;
  logic [1:0] addr_sets_r;
  logic finish_pending_r;
  logic int_r;
  logic fail_r;
  logic acc_r;
  logic [15:0] pend_block_r;
  logic [5:0] pend_page_r;
  logic is_cache_cmd;
  logic first_r;
  logic [15:0] next_block_r;
  logic [5:0] next_page_r;

  assign latency_setting = lat_r;

  // Latency programming; out-of-range values are clamped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lat_r <= `LAT_RESET;
    end else if (latency_write) begin
      if (burst_read_latency < `LAT_MIN) begin
        lat_r <= `LAT_MIN;
      end else begin
        lat_r <= burst_read_latency;
      end
    end
  end

  assign reserved = ((addr_r >= `RSV_MAIN_LO) && (addr_r <= `RSV_MAIN_HI)) ||
    ((addr_r >= `RSV_REG_LO) && (addr_r <= `RSV_REG_HI));
  assign stop_burst = chip_select_n || !hardware_reset_input_n || soft_reset ||
    !write_enable_n;
  assign burst_live = (rd_state_r == RD_BURST) && !stop_burst;
  assign mem_addr = addr_r;

  burst_addr_gen u_addr (
    .addr(addr_r),
    .len(burst_length),
    .next_addr(next_addr)
  );

  // Burst sequencing
  always_ff @(posedge clk) begin
    if (sys_rst || stop_burst) begin
      rd_state_r <= RD_IDLE;
      lat_cnt_r <= '0;
      ready_r <= 1'b0;
    end else begin
      ready_r <= 1'b0;
      unique case (rd_state_r)
        RD_IDLE: begin
          if (!address_latch_strobe_n && burst_clk_en &&
              (read_mode_select || !write_mode_select)) begin
            rd_state_r <= RD_LAT;
            lat_cnt_r <= 3'h1;
          end
        end
        RD_LAT: begin
          if (burst_clk_en) begin
            lat_cnt_r <= lat_cnt_r + 3'h1;
            if (lat_cnt_r == lat_r - 3'h1) begin
              ready_r <= !reserved;
            end
            if (lat_cnt_r == lat_r) begin
              rd_state_r <= RD_BURST;
            end
          end
        end
        RD_BURST: begin
          rd_state_r <= RD_BURST;
        end
      endcase
    end
  end
  assign ready = ready_r;

  // Address register: strobe latches, burst edges advance
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_r <= '0;
    end else if (!address_latch_strobe_n && !chip_select_n && write_enable_n) begin
      addr_r <= addr_in;
    end else if (burst_live && burst_clk_en && f_in_ready) begin
      addr_r <= next_addr;
    end
  end

  // Words enter the FIFO one per enabled clock edge during the burst, none while the address is reserved
  assign f_in_valid = burst_live && burst_clk_en && !reserved;
  assign cycle_start = !address_latch_strobe_n && !chip_select_n;

  read_fifo #(
    .WIDTH(16),
    .DEPTH(4)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(stop_burst || cycle_start),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(mem_rdata),
    .out_valid(f_out_valid),
    .out_ready(burst_clk_en && !output_enable_n),
    .out_data(f_out_data)
  );

  // First word appears asynchronously after the strobe, independent of latency
  always_ff @(posedge clk) begin
    if (sys_rst || chip_select_n) begin
      async_valid_r <= 1'b0;
      data_r <= '0;
    end else if (!address_latch_strobe_n && write_enable_n) begin
      async_valid_r <= 1'b1;
      data_r <= mem_rdata;
    end else if (!read_mode_select || (rd_state_r == RD_LAT && lat_cnt_r == 3'h1)) begin
      // The strobe edge still shows the old address; the latched word lands one edge later
      data_r <= mem_rdata;
    end else if (f_out_valid && burst_clk_en) begin
      data_r <= f_out_data;
    end
  end
  assign data_out = data_r;
  assign data_oe = !chip_select_n && !output_enable_n && async_valid_r;

  // Cache read sequencing
  assign is_cache_cmd = (cmd_code == `CMD_CACHE_FIRST) || (cmd_code == `CMD_CACHE_NEXT) ||
    (cmd_code == `CMD_CACHE_FINISH);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cr_state_r <= CR_IDLE;
      sense_busy_r <= 1'b0;
      xfer_busy_r <= 1'b0;
      sense_cnt_r <= '0;
      xfer_cnt_r <= '0;
      bsa_r <= `BSA_RAM0;
      addr_sets_r <= '0;
      finish_pending_r <= 1'b0;
      fail_r <= 1'b0;
      pend_block_r <= '0;
      pend_page_r <= '0;
      first_r <= 1'b0;
      next_block_r <= '0;
      next_page_r <= '0;
    end else begin
      if (sense_busy_r) begin
        sense_cnt_r <= sense_cnt_r - 8'h01;
        if (sense_cnt_r == 8'h01) begin
          sense_busy_r <= 1'b0;
        end
      end
      if (xfer_busy_r) begin
        xfer_cnt_r <= xfer_cnt_r - 8'h01;
        if (xfer_cnt_r == 8'h01) begin
          xfer_busy_r <= 1'b0;
        end
      end
      if (cmd_write && cr_state_r != CR_IDLE && !is_cache_cmd) begin
        fail_r <= 1'b1;
        first_r <= 1'b0;
        cr_state_r <= CR_IDLE;
      end else begin
        unique case (cr_state_r)
          CR_IDLE: begin
            if (cmd_write && cmd_code == `CMD_LOAD) begin
              sense_busy_r <= 1'b1;
              sense_cnt_r <= `SENSE_CYCLES;
              bsa_r <= buffer_select_addr;
              cr_state_r <= CR_LOAD_SENSE;
            end else if (cmd_write && cmd_code == `CMD_CACHE_FIRST &&
                copy_sector_addr == 2'h0 && flash_sector_addr == 2'h0 &&
                buffer_sector_count == 2'h0 &&
                (buffer_select_addr == `BSA_RAM0 ||
                 buffer_select_addr == `BSA_RAM1)) begin
              fail_r <= 1'b0;
              bsa_r <= buffer_select_addr;
              sense_busy_r <= 1'b1;
              sense_cnt_r <= `SENSE_CYCLES;
              // First page comes from the copy fields; the second waits for the overlap
              pend_block_r <= copy_block_addr;
              pend_page_r <= copy_page_addr;
              next_block_r <= flash_block_addr;
              next_page_r <= flash_page_addr;
              first_r <= 1'b1;
              addr_sets_r <= 2'h1;
              finish_pending_r <= 1'b0;
              cr_state_r <= CR_OVERLAP;
            end else if (cmd_write && cmd_code == `CMD_CACHE_FIRST) begin
              fail_r <= 1'b1;
            end
          end
          CR_LOAD_SENSE: begin
            if (!sense_busy_r) begin
              xfer_busy_r <= 1'b1;
              xfer_cnt_r <= `XFER_CYCLES;
              cr_state_r <= CR_LOAD_XFER;
            end
          end
          CR_LOAD_XFER: begin
            if (!xfer_busy_r) begin
              cr_state_r <= CR_IDLE;
            end
          end
          CR_OVERLAP: begin
            if (first_r) begin
              if (!sense_busy_r) begin
                xfer_busy_r <= 1'b1;
                xfer_cnt_r <= `XFER_CYCLES;
                sense_busy_r <= 1'b1;
                sense_cnt_r <= `SENSE_CYCLES;
                pend_block_r <= next_block_r;
                pend_page_r <= next_page_r;
                first_r <= 1'b0;
              end
            end else if (!sense_busy_r && !xfer_busy_r) begin
              cr_state_r <= CR_WAIT;
            end
          end
          CR_WAIT: begin
            if (cmd_write && cmd_code == `CMD_CACHE_NEXT) begin
              xfer_busy_r <= 1'b1;
              xfer_cnt_r <= `XFER_CYCLES;
              sense_busy_r <= 1'b1;
              sense_cnt_r <= `SENSE_CYCLES;
              pend_block_r <= flash_block_addr;
              pend_page_r <= flash_page_addr;
              if (addr_sets_r != 2'h3) begin
                addr_sets_r <= addr_sets_r + 2'h1;
              end
              bsa_r <= (bsa_r == `BSA_RAM0) ? `BSA_RAM1 : `BSA_RAM0;
              cr_state_r <= CR_OVERLAP;
            end else if (cmd_write && cmd_code == `CMD_CACHE_FINISH) begin
              xfer_busy_r <= 1'b1;
              xfer_cnt_r <= `XFER_CYCLES;
              bsa_r <= (bsa_r == `BSA_RAM0) ? `BSA_RAM1 : `BSA_RAM0;
              finish_pending_r <= 1'b1;
              cr_state_r <= CR_FINISH_XFER;
            end
          end
          CR_FINISH_XFER: begin
            if (!xfer_busy_r) begin
              finish_pending_r <= 1'b0;
              cr_state_r <= CR_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Interrupt line: lowered by cache commands in auto mode or a host clear, not by a load; set wins over a host clear on the same edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_r <= 1'b1;
    end else if (((cr_state_r == CR_OVERLAP && !first_r) || cr_state_r == CR_FINISH_XFER ||
        cr_state_r == CR_LOAD_XFER) && !xfer_busy_r && !sense_busy_r) begin
      int_r <= 1'b1;
    end else if (cmd_write && auto_int_mode && is_cache_cmd) begin
      int_r <= 1'b0;
    end else if (int_clear) begin
      int_r <= 1'b0;
    end
  end

  // Address writes while busy honoured from the second setting onward
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_r <= 1'b0;
    end else begin
      acc_r <= addr_write && (int_r || addr_sets_r >= 2'h2);
    end
  end

  assign int_out = int_r;
  assign sense_active = sense_busy_r;
  assign xfer_active = xfer_busy_r;
  assign xfer_buffer = bsa_r;
  assign sense_block = pend_block_r;
  assign sense_page = pend_page_r;
  assign cache_fail = fail_r;
  assign addr_accepted = acc_r;
endmodule

// ==== sim/buffer_mem_model.sv ====
// Buffer memory stand-in answering every address at once with a fixed pattern.
// Assumes the port presents a registered address; no wait states are modelled.
`timescale 1ns/1ps
module buffer_mem_model (
  input wire logic [15:0] mem_addr,
  output logic [15:0] mem_rdata
);
  // Pattern differs from the address, so a stuck address bus still shows
  assign mem_rdata = mem_addr ^ 16'hA5C3;
endmodule

// ==== sim/flash_host_read_port_assertions.sv ====
// Concurrent checks on the pins of the flash host read port.
// Assumes it is bound onto flash_host_read_port; one clock domain.
`timescale 1ns/1ps
`include "flash_read_map.svh"
module flash_read_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic hardware_reset_input_n,
  input wire logic soft_reset,
  input wire logic data_oe,
  input wire logic ready,
  input wire logic [2:0] latency_setting,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_code,
  input wire logic auto_int_mode,
  input wire logic int_out,
  input wire logic sense_active,
  input wire logic xfer_active,
  input wire logic cache_fail
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Set once a sense has finished, spent by the transfer that moves that page
  logic sensed_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sensed_r <= 1'b0;
    end else if ($fell(sense_active)) begin
      sensed_r <= 1'b1;
    end else if ($rose(xfer_active)) begin
      sensed_r <= 1'b0;
    end
  end
  a_oe_when_selected: assert property (
    data_oe |-> !chip_select_n && !output_enable_n) else $error("data driven while deselected");
  a_lat_reset_value: assert property (
    $fell(sys_rst) |-> latency_setting == `LAT_RESET) else $error("latency reset value wrong");
  a_lat_in_range: assert property (
    latency_setting >= `LAT_MIN) else $error("latency below minimum");
  a_ready_one_pulse: assert property (
    ready |=> !ready) else $error("ready held more than one cycle");
  a_burst_stops: assert property (
    (chip_select_n || !hardware_reset_input_n || soft_reset || !write_enable_n) |=> !ready)
    else $error("ready after burst stop");
  a_sense_then_xfer: assert property (
    $rose(xfer_active) |-> sensed_r) else $error("transfer without prior sense");
  a_auto_int_low: assert property (
    cmd_write && auto_int_mode
    && (cmd_code == `CMD_CACHE_FIRST || cmd_code == `CMD_CACHE_NEXT) |=> !int_out)
    else $error("interrupt not lowered by cache command");
  a_int_after_xfer: assert property (
    $rose(int_out) |-> !$past(xfer_active) && !$past(sense_active)
    && ($past(xfer_active, 2) || $past(sense_active, 2)))
    else $error("interrupt raised without finished transfer");
  c_ready: cover property (ready);
  c_xfer: cover property ($rose(xfer_active));
  c_fail: cover property ($rose(cache_fail));
endmodule
bind flash_host_read_port flash_read_checker u_checker (.clk, .sys_rst, .chip_select_n,
  .output_enable_n, .write_enable_n, .hardware_reset_input_n, .soft_reset, .data_oe, .ready,
  .latency_setting, .cmd_write, .cmd_code, .auto_int_mode, .int_out, .sense_active,
  .xfer_active, .cache_fail);

// ==== sim/flash_host_read_port_tb_top.sv ====
// Bench for the flash host read port: async reads, bursts, latency and cache read.
// Assumes the checker binds itself and the memory model answers mem_addr at once.
`timescale 1ns/1ps
module flash_host_read_port_tb_top
  import flash_read_pkg::*;
;
  logic clk = 0, sys_rst = 1, chip_select_n = 1, output_enable_n = 1, write_enable_n = 1;
  logic address_latch_strobe_n = 1, hardware_reset_input_n = 1, soft_reset = 0;
  logic burst_clk_en = 0, read_mode_select = 0, write_mode_select = 0, latency_write = 0;
  logic high_frequency_flag = 0, cmd_write = 0, addr_write = 0, auto_int_mode = 1;
  logic [2:0] burst_read_latency = 3'h4;
  logic [3:0] buffer_select_addr = 4'h8;
  logic [5:0] flash_page_addr = 6'h01, copy_page_addr = 6'h00;
  logic [15:0] addr_in = 16'h0000, cmd_code = 16'h0000, lfsr = 16'hD143;
  logic [15:0] flash_block_addr = 16'h0022, copy_block_addr = 16'h0011;
  burst_len_e burst_length = BL_4;
  logic data_oe, ready, int_out, sense_active, xfer_active, cache_fail, addr_accepted;
  logic [2:0] latency_setting;
  logic [3:0] xfer_buffer;
  logic [5:0] sense_page;
  logic [15:0] data_out, mem_addr, mem_rdata, sense_block;
  logic [15:0] sense_q[$];
  logic [3:0] xfer_q[$];
  int n_errors = 0, checks_done = 0, lat_m = 4;
  flash_host_read_port DUT (.clk, .sys_rst, .chip_select_n, .output_enable_n, .write_enable_n,
    .address_latch_strobe_n, .hardware_reset_input_n, .soft_reset, .burst_clk_en, .addr_in,
    .data_in(16'h0000), .data_out, .data_oe, .ready, .read_mode_select, .write_mode_select,
    .burst_read_latency, .latency_write, .high_frequency_flag, .burst_length, .latency_setting,
    .mem_addr, .mem_rdata, .cmd_write, .cmd_code, .addr_write, .auto_int_mode, .int_clear(1'b0),
    .buffer_select_addr, .buffer_sector_count(2'h0), .flash_block_addr, .flash_page_addr,
    .flash_sector_addr(2'h0), .copy_block_addr, .copy_page_addr, .copy_sector_addr(2'h0),
    .int_out, .sense_active, .xfer_active, .xfer_buffer, .sense_block, .sense_page,
    .cache_fail, .addr_accepted);
  buffer_mem_model u_mem (.mem_addr, .mem_rdata);
  always #20 clk = ~clk;
  // Record each new page sensed and each new target buffer, in order
  always @(posedge clk) begin
    if (sense_active && (sense_q.size() == 0 || sense_q[$] !== sense_block))
      sense_q.push_back(sense_block);
    if (xfer_active && (xfer_q.size() == 0 || xfer_q[$] !== xfer_buffer))
      xfer_q.push_back(xfer_buffer);
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] word_of(input logic [15:0] a);
    return a ^ 16'hA5C3;
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] v, input burst_len_e bl);
    logic [15:0] msk;
    msk = (bl == BL_CONT) ? 16'hFFFF : (16'h0004 << (int'(bl) - 1)) - 16'h0001;
    return (v & ~msk) | ((v + 16'h0001) & msk);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic note(input string s);
    $display("test %s done: %0d checks, %0d mismatches", s, checks_done, n_errors);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_int();
    int k;
    for (k = 0; k < 400; k++) begin
      tick(1);
      #1;
      if (int_out === 1'b1) break;
    end
    if (k == 400) check(16'(int_out), 16'h0001);
  endtask
  task automatic cmd(input logic [15:0] c, input bit busy);
    tick(1);
    cmd_code <= c;
    cmd_write <= 1;
    tick(1);
    cmd_write <= 0;
    #1;
    if (busy) check(16'(int_out), 16'h0000);
  endtask
  task automatic burst(input logic [15:0] a, input burst_len_e bl, input bit rsv);
    logic [15:0] m, last;
    int rdy_n, rdy_k;
    m = a;
    last = ~a;
    rdy_n = 0;
    rdy_k = 0;
    tick(1);
    burst_length <= bl;
    addr_in <= a;
    chip_select_n <= 0;
    output_enable_n <= 0;
    address_latch_strobe_n <= 0;
    burst_clk_en <= 1;
    tick(1);
    address_latch_strobe_n <= 1;
    for (int k = 1; k <= 48; k++) begin
      tick(1);
      #1;
      if (k == 1 && !rsv) check(data_out, word_of(a));
      if (ready === 1'b1) begin
        if (rdy_n == 0) rdy_k = k;
        rdy_n++;
      end
      if (!rsv && mem_addr !== last) begin
        check(mem_addr, m);
        last = mem_addr;
        m = nxt(m, bl);
      end
    end
    check(16'(rdy_n), rsv ? 16'h0000 : 16'h0001);
    if (!rsv) check(16'(rdy_k), 16'(lat_m - 1));
    tick(1);
    if (bl == BL_CONT) write_enable_n <= 0;
    else chip_select_n <= 1;
    tick(1);
    write_enable_n <= 1;
    output_enable_n <= 1;
    tick(2);
    #1;
    m = mem_addr;
    tick(4);
    #1;
    check(mem_addr, m);
    tick(1);
    chip_select_n <= 1;
    burst_clk_en <= 0;
  endtask
  initial begin
    logic [2:0] lat_in [4];
    logic [15:0] blk_e [3];
    logic [3:0] buf_e [3];
    logic [15:0] a;
    lat_in = '{3'h7, 3'h2, 3'h3, 3'h5};
    blk_e = '{16'h0011, 16'h0022, 16'h0033};
    buf_e = '{4'h8, 4'hC, 4'h8};
    tick(10);
    sys_rst <= 0;
    tick(1);
    #1;
    check(16'(latency_setting), 16'h0004);
    check(16'(xfer_buffer), 16'h0008);
    note("reset");
    foreach (lat_in[i]) begin
      tick(1);
      burst_read_latency <= lat_in[i];
      latency_write <= 1;
      tick(1);
      latency_write <= 0;
      lat_m = (lat_in[i] < 3'h3) ? 3 : int'(lat_in[i]);
      #1;
      check(16'(latency_setting), 16'(lat_m));
    end
    note("latency");
    repeat (2) begin
      lfsr = lfsr_next(lfsr);
      a = 16'h0200 + (lfsr & 16'h03FF);
      tick(1);
      addr_in <= a;
      chip_select_n <= 0;
      output_enable_n <= 0;
      address_latch_strobe_n <= 0;
      tick(1);
      address_latch_strobe_n <= 1;
      tick(1);
      #1;
      check(data_out, word_of(a));
      check(16'(data_oe), 16'h0001);
      tick(1);
      output_enable_n <= 1;
      #1;
      check(16'(data_oe), 16'h0000);
      tick(1);
      chip_select_n <= 1;
    end
    note("async read");
    tick(1);
    read_mode_select <= 1;
    for (int i = 0; i < 7; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i < 5) ? 16'h0200 + (lfsr & 16'h01FF) : ((i == 5) ? 16'h0A40 : 16'h9100);
      burst(a, burst_len_e'(i % 5), i >= 5);
    end
    note("burst");
    tick(1);
    read_mode_select <= 0;
    sense_q.delete();
    xfer_q.delete();
    cmd(16'h000E, 1'b1);
    wait_int();
    tick(1);
    flash_block_addr <= 16'h0033;
    cmd(16'h000F, 1'b1);
    tick(1);
    flash_block_addr <= 16'h0044;
    addr_write <= 1;
    tick(1);
    addr_write <= 0;
    #1;
    check(16'(addr_accepted), 16'h0001);
    wait_int();
    cmd(16'h000C, 1'b0);
    tick(24);
    wait_int();
    for (int i = 0; i < 3; i++) begin
      check(sense_q[i], blk_e[i]);
      check(16'(xfer_q[i]), 16'(buf_e[i]));
    end
    check(16'(sense_page), 16'(flash_page_addr));
    cmd(16'h000E, 1'b1);
    cmd(16'h0000, 1'b0);
    tick(2);
    #1;
    check(16'(cache_fail), 16'h0001);
    note("cache read");
    tick(1);
    sys_rst <= 1;
    tick(3);
    sys_rst <= 0;
    tick(1);
    #1;
    check(16'(latency_setting), 16'h0004);
    note("second reset");
    wrap_up();
  end
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end
endmodule
